// [ctk_pkg.sv]
/*
  Package for the event tracker: event indices, instruction codes, register
  offsets and reset values. Assumes a single clock domain and an APB master.
*/
package ctk_pkg;
  localparam int unsigned CTK_EVENTS = 16;
  // Event flag positions.
  localparam logic [3:0] EV_INT = 4'h0;
  localparam logic [3:0] EV_MATCH1 = 4'h1;
  localparam logic [3:0] EV_MATCH2 = 4'h2;
  localparam logic [3:0] EV_MATCH3 = 4'h3;
  localparam logic [3:0] EV_SEL1 = 4'h4;
  localparam logic [3:0] EV_SEL4 = 4'h7;
  localparam logic [3:0] EV_PIN = 4'h8;
  localparam logic [3:0] EV_BLK_WRAP = 4'h9;
  localparam logic [3:0] EV_STR_EMPTY = 4'hA;
  localparam logic [3:0] EV_STR_DONE = 4'hB;
  localparam logic [3:0] EV_STR_ROLL = 4'hC;
  localparam logic [3:0] EV_STR_LUT = 4'hD;
  localparam logic [3:0] EV_ATTN = 4'hE;
  localparam logic [3:0] EV_SOLVER = 4'hF;
  // Register byte offsets.
  localparam logic [7:0] OFS_FLAGS = 8'h00;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
  localparam logic [7:0] OFS_COUNTER = 8'h0C;
  // Reset values.
  localparam logic [15:0] RST_FLAGS = 16'h0000;
  localparam logic [15:0] RST_IRQ_MASK = 16'h0000;
  localparam logic [31:0] RST_COUNTER = 32'h00000000;
  localparam logic [8:0] RST_SEL_CFG = 9'h000;
  // Instructions served by the tracker.
  typedef enum logic [3:0] {
    CTK_OP_ARM_MATCH,
    CTK_OP_ATTENTION,
    CTK_OP_BRANCH_SET,
    CTK_OP_BRANCH_CLR,
    CTK_OP_POLL,
    CTK_OP_PIN_SETUP,
    CTK_OP_SEL_SETUP,
    CTK_OP_WAIT,
    CTK_OP_QUEUE
  } ctk_op_e;
  typedef enum logic [1:0] {
    CTK_ST_IDLE,
    CTK_ST_WAIT,
    CTK_ST_DONE
  } ctk_state_e;
endpackage

// [ctk_event_tracker.sv]
/*
  Event tracker of one processor: sixteen sticky event flags, counter-match
  arming, attention strobes, pin-pattern and selectable event setup, branch,
  poll and wait services, plus an APB register view with an interrupt.
  Assumes the pipeline holds an instruction until it is accepted and that
  event sources pulse for one pclk cycle on the same clock.
*/
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module ctk_event_tracker
  import ctk_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic instr_valid,
  input wire ctk_op_e instr_op,
  input wire logic [3:0] instr_event,
  input wire logic [31:0] instr_d,
  input wire logic [31:0] instr_s,
  input wire logic instr_wc,
  input wire logic instr_wz,
  input wire logic flag_c_in,
  input wire logic flag_z_in,
  output logic instr_busy,
  output logic instr_done,
  output logic [31:0] result_d,
  output logic result_c,
  output logic result_z,
  output logic result_c_we,
  output logic result_z_we,
  output logic branch_take,
  input wire logic [15:0] event_src_pulse,
  input wire logic attention_event_in,
  output logic [15:0] attention_strobe,
  input wire logic [31:0] pin_input_low_bank,
  input wire logic [31:0] pin_input_high_bank,
  output logic [3:0][8:0] sel_cfg,
  output logic [31:0] free_running_counter,
  output logic [15:0] event_flags
);

  // ********************************************************
  // Declarations
  // ********************************************************
  ctk_state_e state;
  logic [3:0] cur_ev;
  logic cur_wc;
  logic cur_wz;
  logic accept;
  logic wait_hit;
  logic wait_tmo;
  logic [31:0] tmo_value;
  logic q_pend;
  logic tmo_armed;
  logic [15:0] set_vec;
  logic [15:0] clr_vec;
  logic [2:0] match_hit;
  logic [2:0] match_armed;
  logic [2:0][31:0] match_target;
  logic [63:0] pin_s1;
  logic [63:0] pin_s2;
  logic [63:0] pin_s3;
  logic [63:0] pin_stable;
  logic pm_hi;
  logic pm_ne;
  logic pm_on;
  logic [31:0] pm_mask;
  logic [31:0] pm_match;
  logic pm_cond;
  logic pm_prev;
  logic pm_hit;
  logic [15:0] irq_status;
  logic [15:0] irq_mask;
  logic setup_phase;
  logic access_phase;
  logic addr_ok;

  // ********************************************************
  // Instruction sequencing
  // ********************************************************

  // Handshake is combinational so the pipeline sees acceptance in the same cycle.
  assign accept = (state == CTK_ST_IDLE) && instr_valid;
  assign instr_busy = (state != CTK_ST_IDLE);
  assign instr_done = (state == CTK_ST_DONE);
  assign wait_hit = (state == CTK_ST_WAIT) && event_flags[cur_ev];
  assign wait_tmo = (state == CTK_ST_WAIT) && !event_flags[cur_ev] && tmo_armed
                    && (free_running_counter == tmo_value);

  // Every instruction answers on the edge after acceptance; a wait parks in WAIT.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= CTK_ST_IDLE;
    end else begin
      case (state)
        CTK_ST_IDLE: begin
          if (accept && instr_op == CTK_OP_WAIT) begin
            state <= CTK_ST_WAIT;
          end else if (accept) begin
            state <= CTK_ST_DONE;
          end
        end
        CTK_ST_WAIT: begin
          if (wait_hit || wait_tmo) begin
            state <= CTK_ST_DONE;
          end
        end
        default: begin
          state <= CTK_ST_IDLE;
        end
      endcase
    end
  end

  // Latched operands of the instruction in flight.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ev <= 4'h0;
      cur_wc <= 1'b0;
      cur_wz <= 1'b0;
    end else if (accept) begin
      cur_ev <= instr_event;
      cur_wc <= instr_wc;
      cur_wz <= instr_wz;
    end
  end

  // A queue prefix is consumed by the very next instruction, wait or not.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmo_value <= RST_COUNTER;
      q_pend <= 1'b0;
      tmo_armed <= 1'b0;
    end else begin
      if (accept && instr_op == CTK_OP_QUEUE) begin
        tmo_value <= instr_d;
        q_pend <= 1'b1;
      end else if (accept) begin
        q_pend <= 1'b0;
        tmo_armed <= (instr_op == CTK_OP_WAIT) && q_pend;
      end else if (instr_done) begin
        tmo_armed <= 1'b0;
      end
    end
  end

  // Results are registered so the pipeline samples them with instr_done.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_d <= 32'h00000000;
      result_c <= 1'b0;
      result_z <= 1'b0;
      result_c_we <= 1'b0;
      result_z_we <= 1'b0;
      branch_take <= 1'b0;
    end else if (accept) begin
      result_c_we <= 1'b0;
      result_z_we <= 1'b0;
      branch_take <= 1'b0;
      case (instr_op)
        CTK_OP_ARM_MATCH: begin
          result_d <= instr_d + instr_s;
        end
        CTK_OP_BRANCH_SET: begin
          branch_take <= event_flags[instr_event];
        end
        CTK_OP_BRANCH_CLR: begin
          branch_take <= !event_flags[instr_event];
        end
        CTK_OP_POLL: begin
          result_c <= event_flags[instr_event];
          result_z <= event_flags[instr_event];
          result_c_we <= instr_wc;
          result_z_we <= instr_wz;
        end
        default: begin
        end
      endcase
    end else if (wait_hit || wait_tmo) begin
      result_c <= wait_tmo;
      result_z <= wait_tmo;
      result_c_we <= cur_wc;
      result_z_we <= cur_wz;
    end
  end

  // ********************************************************
  // Counter and counter-match events
  // ********************************************************

  // The counter free-runs and wraps; matches therefore repeat every 2^32 clocks.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      free_running_counter <= RST_COUNTER;
    end else begin
      free_running_counter <= free_running_counter + 32'h00000001;
    end
  end

  // One comparator per counter-match event; each stays armed after firing.
  for (genvar k = 0; k < 3; k++) begin : g_match
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        match_target[k] <= RST_COUNTER;
        match_armed[k] <= 1'b0;
      end else if (accept && instr_op == CTK_OP_ARM_MATCH && instr_event == EV_MATCH1 + 4'(k)) begin
        match_target[k] <= instr_d + instr_s;
        match_armed[k] <= 1'b1;
      end
    end
    assign match_hit[k] = match_armed[k] && (free_running_counter == match_target[k]);
  end

  // ********************************************************
  // Attention strobe and selectable events
  // ********************************************************

  // The outgoing strobe lasts exactly one cycle per instruction.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      attention_strobe <= 16'h0000;
    end else if (accept && instr_op == CTK_OP_ATTENTION) begin
      attention_strobe <= instr_d[15:0];
    end else begin
      attention_strobe <= 16'h0000;
    end
  end

  // The configuration code is handed to the event source logic unchanged.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_cfg <= {4{RST_SEL_CFG}};
    end else if (accept && instr_op == CTK_OP_SEL_SETUP && instr_event >= EV_SEL1 && instr_event <= EV_SEL4) begin
      sel_cfg[instr_event[1:0]] <= instr_d[8:0];
    end
  end

  // ********************************************************
  // Pin pattern event
  // ********************************************************

  // Pins are asynchronous; a bit changes only once stages two and three agree.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1 <= 64'h0000000000000000;
      pin_s2 <= 64'h0000000000000000;
      pin_s3 <= 64'h0000000000000000;
      pin_stable <= 64'h0000000000000000;
    end else begin
      pin_s1 <= {pin_input_high_bank, pin_input_low_bank};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_stable <= (pin_s2 & pin_s3) | (pin_stable & (pin_s2 | pin_s3));
    end
  end

  // Pattern setup captures bank and sense from the condition flags.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pm_hi <= 1'b0;
      pm_ne <= 1'b0;
      pm_on <= 1'b0;
      pm_mask <= 32'h00000000;
      pm_match <= 32'h00000000;
    end else if (accept && instr_op == CTK_OP_PIN_SETUP) begin
      pm_hi <= flag_c_in;
      pm_ne <= flag_z_in;
      pm_on <= 1'b1;
      pm_mask <= instr_d;
      pm_match <= instr_s;
    end
  end

  // The event fires when the comparison becomes true, not while it stays true.
  assign pm_cond = (((pm_hi ? pin_stable[63:32] : pin_stable[31:0]) & pm_mask) == pm_match) ^ pm_ne;
  assign pm_hit = pm_on && pm_cond && !pm_prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pm_prev <= 1'b0;
    end else begin
      pm_prev <= pm_on && pm_cond;
    end
  end

  // ********************************************************
  // Sticky event flags
  // ********************************************************

  always_comb begin
    set_vec = event_src_pulse;
    set_vec[EV_MATCH1] = event_src_pulse[EV_MATCH1] | match_hit[0];
    set_vec[EV_MATCH2] = event_src_pulse[EV_MATCH2] | match_hit[1];
    set_vec[EV_MATCH3] = event_src_pulse[EV_MATCH3] | match_hit[2];
    set_vec[EV_PIN] = event_src_pulse[EV_PIN] | pm_hit;
    set_vec[EV_ATTN] = event_src_pulse[EV_ATTN] | attention_event_in;
    clr_vec = 16'h0000;
    if (accept && instr_op == CTK_OP_POLL) begin
      clr_vec[instr_event] = 1'b1;
    end
    if (wait_hit) begin
      clr_vec[cur_ev] = 1'b1;
    end
  end

  // A pulse landing on the clearing edge keeps the flag set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_flags <= RST_FLAGS;
    end else begin
      event_flags <= (event_flags & ~clr_vec) | set_vec;
    end
  end

  // ********************************************************
  // APB register view and interrupt
  // ********************************************************

  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;
  assign addr_ok = (paddr == OFS_FLAGS) || (paddr == OFS_IRQ_STATUS) || (paddr == OFS_IRQ_MASK)
                   || (paddr == OFS_COUNTER);
  // Zero wait states: every access completes in its first access cycle.
  assign pready = 1'b1;
  assign pslverr = access_phase && !addr_ok;

  // Read data is captured in the setup cycle, so the counter shows that cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup_phase && !pwrite) begin
      if (paddr == OFS_FLAGS) begin
        prdata <= {16'h0000, event_flags};
      end else if (paddr == OFS_IRQ_STATUS) begin
        prdata <= {16'h0000, irq_status};
      end else if (paddr == OFS_IRQ_MASK) begin
        prdata <= {16'h0000, irq_mask};
      end else if (paddr == OFS_COUNTER) begin
        prdata <= free_running_counter;
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  // Interrupt status is write-one-to-clear; a new event in that cycle wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= RST_FLAGS;
      irq_mask <= RST_IRQ_MASK;
    end else begin
      if (access_phase && pwrite && paddr == OFS_IRQ_STATUS) begin
        irq_status <= (irq_status & ~pwdata[15:0]) | set_vec;
      end else begin
        irq_status <= irq_status | set_vec;
      end
      if (access_phase && pwrite && paddr == OFS_IRQ_MASK) begin
        irq_mask <= pwdata[15:0];
      end
    end
  end

  assign irq = |(irq_status & irq_mask);

  // ********************************************************
  // Assertions
  // ********************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_arm_sum_back: assert property (accept && instr_op == CTK_OP_ARM_MATCH |=>
    instr_done && result_d == $past(instr_d) + $past(instr_s)) else $error("arm sum wrong");
  a_attn_strobe_once: assert property (accept && instr_op == CTK_OP_ATTENTION |=>
    attention_strobe == $past(instr_d[15:0]) ##1 attention_strobe == 16'h0000) else $error("strobe wrong");
  a_branch_on_set: assert property (accept && instr_op == CTK_OP_BRANCH_SET |=>
    instr_done && branch_take == $past(event_flags[instr_event])) else $error("set branch wrong");
  a_branch_on_clear: assert property (accept && instr_op == CTK_OP_BRANCH_CLR |=>
    instr_done && branch_take != $past(event_flags[instr_event])) else $error("clear branch wrong");
  a_poll_flag_copy: assert property (accept && instr_op == CTK_OP_POLL && !set_vec[instr_event] |=>
    instr_done && result_c == $past(event_flags[instr_event]) && !event_flags[cur_ev]) else $error("poll wrong");
  a_pin_setup_flags: assert property (accept && instr_op == CTK_OP_PIN_SETUP |=>
    pm_hi == $past(flag_c_in) && pm_ne == $past(flag_z_in) && pm_mask == $past(instr_d)) else $error("pin setup wrong");
  a_sel_cfg_load: assert property (accept && instr_op == CTK_OP_SEL_SETUP && instr_event == EV_SEL1 |=>
    sel_cfg[0] == $past(instr_d[8:0])) else $error("select config wrong");
  a_wait_stall_hold: assert property (state == CTK_ST_WAIT && !event_flags[cur_ev] && !wait_tmo |=>
    state == CTK_ST_WAIT && !instr_done) else $error("wait left early");
  a_wait_flag_end: assert property (wait_hit && !set_vec[cur_ev] |=>
    instr_done && !result_c && !event_flags[$past(cur_ev)]) else $error("wait end wrong");
  a_wait_timeout_end: assert property (wait_tmo |=> instr_done && result_c) else $error("timeout wrong");
  a_flag_set_wins: assert property (set_vec != 16'h0000 |=>
    (event_flags & $past(set_vec)) == $past(set_vec)) else $error("set lost");

endmodule // ctk_event_tracker

// [ctk_pipe_model.sv]
/*
  Pipeline model: issues one instruction at a time to the event tracker and
  keeps what came back. Assumes the tracker's busy/done handshake on pclk.
*/
`timescale 1ns/1ps
module ctk_pipe_model
  import ctk_pkg::*;
(
  input wire logic pclk,
  output logic instr_valid,
  output ctk_op_e instr_op,
  output logic [3:0] instr_event,
  output logic [31:0] instr_d,
  output logic [31:0] instr_s,
  output logic instr_wc,
  output logic instr_wz,
  input wire logic instr_busy,
  input wire logic instr_done,
  input wire logic [31:0] result_d,
  input wire logic result_c,
  input wire logic result_z,
  input wire logic result_c_we,
  input wire logic result_z_we,
  input wire logic branch_take,
  input wire logic [15:0] attention_strobe
);
  logic [31:0] res_d;
  logic [3:0] res_flags;
  logic res_take;
  int lat;
  logic timed_out;
  logic [15:0] attn_seen = 16'h0000;
  int attn_cycles = 0;

  initial begin
    instr_valid = 1'b0;
    instr_op = CTK_OP_POLL;
    instr_event = 4'h0;
    instr_d = 32'h00000000;
    instr_s = 32'h00000000;
    instr_wc = 1'b0;
    instr_wz = 1'b0;
  end

  // Each strobe cycle is counted so a pulse stretched by one cycle shows up.
  always @(posedge pclk) begin
    if (attention_strobe !== 16'h0000) begin
      attn_seen <= attention_strobe;
      attn_cycles <= attn_cycles + 1;
    end
  end

  // The request is held until the edge where the tracker is not busy.
  task automatic issue(input ctk_op_e op, input logic [3:0] ev, input logic [31:0] d, input logic [31:0] s,
                       input logic wc, input logic wz);
    int n;
    instr_op <= op;
    instr_event <= ev;
    instr_d <= d;
    instr_s <= s;
    instr_wc <= wc;
    instr_wz <= wz;
    instr_valid <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (instr_busy !== 1'b0 && n < 200);
    instr_valid <= 1'b0;
    lat = 0;
    do begin @(posedge pclk); lat++; end while (instr_done !== 1'b1 && lat < 300);
    timed_out = (n >= 200) || (lat >= 300);
    res_d = result_d;
    res_flags = {result_c, result_z, result_c_we, result_z_we};
    res_take = branch_take;
  endtask
endmodule // ctk_pipe_model

// [test_ctk_event_tracker.sv]
/*
  Testbench of the event tracker: APB tasks, instruction sequences through the
  pipeline model, expectations worked out from the event rules.
  Assumes zero-wait APB and a one-cycle done pulse after each instruction.
*/
`timescale 1ns/1ps
module test_ctk_event_tracker;
  import ctk_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, result_d, instr_d, instr_s, free_running_counter, rd, d, t;
  logic pready, pslverr, irq, last_err, instr_valid, instr_wc, instr_wz, instr_busy, instr_done;
  logic result_c, result_z, result_c_we, result_z_we, branch_take;
  logic flag_c_in = 1'b0;
  logic flag_z_in = 1'b0;
  logic attention_event_in = 1'b0;
  logic [15:0] event_src_pulse = 16'h0000;
  logic [15:0] attention_strobe, event_flags;
  logic [31:0] pin_low = 32'h00000000;
  logic [31:0] pin_high = 32'h00000000;
  logic [3:0] instr_event;
  logic [3:0][8:0] sel_cfg;
  ctk_op_e instr_op;
  int bad_count = 0;
  int check_count = 0;
  int n;

  // 40 MHz system clock.
  always #12.5 pclk = ~pclk;

  ctk_event_tracker ctk_event_tracker_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .instr_valid(instr_valid), .instr_op(instr_op), .instr_event(instr_event), .instr_d(instr_d),
    .instr_s(instr_s), .instr_wc(instr_wc), .instr_wz(instr_wz), .flag_c_in(flag_c_in), .flag_z_in(flag_z_in),
    .instr_busy(instr_busy), .instr_done(instr_done), .result_d(result_d), .result_c(result_c),
    .result_z(result_z), .result_c_we(result_c_we), .result_z_we(result_z_we), .branch_take(branch_take),
    .event_src_pulse(event_src_pulse), .attention_event_in(attention_event_in),
    .attention_strobe(attention_strobe), .pin_input_low_bank(pin_low), .pin_input_high_bank(pin_high),
    .sel_cfg(sel_cfg), .free_running_counter(free_running_counter), .event_flags(event_flags));

  ctk_pipe_model ctk_pipe_model_i (.pclk(pclk), .instr_valid(instr_valid), .instr_op(instr_op),
    .instr_event(instr_event), .instr_d(instr_d), .instr_s(instr_s), .instr_wc(instr_wc), .instr_wz(instr_wz),
    .instr_busy(instr_busy), .instr_done(instr_done), .result_d(result_d), .result_c(result_c),
    .result_z(result_z), .result_c_we(result_c_we), .result_z_we(result_z_we), .branch_take(branch_take),
    .attention_strobe(attention_strobe));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic finish_test();
    if (bad_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Setup, access until pready, then an idle cycle so psel is never set twice at one edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (k >= 50) begin bad_count++; $display("[ERR] %0t bus never ready", $time); finish_test(); end
  endtask

  task automatic run(input ctk_op_e op, input logic [3:0] ev, input logic [31:0] dd, input logic [31:0] s,
                     input logic wc, input logic wz);
    ctk_pipe_model_i.issue(op, ev, dd, s, wc, wz);
    if (ctk_pipe_model_i.timed_out) begin
      bad_count++;
      $display("[ERR] %0t instruction never completed", $time);
      finish_test();
    end
  endtask

  // Index 14 is the attention flag, fed by its own input.
  task automatic pulse(input int i);
    if (i == 14) attention_event_in <= 1'b1;
    else event_src_pulse <= 16'h0001 << i;
    @(posedge pclk);
    attention_event_in <= 1'b0;
    event_src_pulse <= 16'h0000;
    @(posedge pclk);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFS_FLAGS, 32'h0, rd); chk(rd, {16'h0000, RST_FLAGS});
    apb(1'b0, OFS_IRQ_MASK, 32'h0, rd); chk(rd, {16'h0000, RST_IRQ_MASK});
    apb(1'b0, 8'h10, 32'h0, rd); chk({rd[30:0], last_err}, 32'h00000001);
    // Arm a match a short way ahead and watch the flag arrive at that count.
    d = free_running_counter;
    run(CTK_OP_ARM_MATCH, EV_MATCH1, d, 32'd24, 1'b0, 1'b0); chk(ctk_pipe_model_i.res_d, d + 32'd24);
    chk(ctk_pipe_model_i.lat, 1);
    n = 0;
    while (event_flags[EV_MATCH1] !== 1'b1 && n < 80) begin @(posedge pclk); n++; end
    t = free_running_counter - d - 32'd24;
    chk({31'h0, t >= 1 && t <= 3}, 1);
    for (int k = 0; k < 4; k++) begin
      run(k[0] ? CTK_OP_BRANCH_CLR : CTK_OP_BRANCH_SET, k[1] ? EV_MATCH2 : EV_MATCH1, 0, 0, 1'b0, 1'b0);
      chk(ctk_pipe_model_i.res_take, k[0] == k[1]);
    end
    // Both condition outputs carry the polled flag; only the write enables follow wc and wz.
    run(CTK_OP_POLL, EV_MATCH1, 0, 0, 1'b1, 1'b0); chk(ctk_pipe_model_i.res_flags, 4'hE);
    run(CTK_OP_POLL, EV_MATCH1, 0, 0, 1'b0, 1'b1); chk(ctk_pipe_model_i.res_flags, 4'h1);
    // Every flag is set by a pulse, stays set, and is cleared by a poll.
    for (int i = 0; i < 16; i++) begin
      pulse(i);
      repeat (4) @(posedge pclk);
      chk(event_flags[i], 1);
      run(CTK_OP_POLL, 4'(i), 0, 0, 1'b1, 1'b1); chk(ctk_pipe_model_i.res_flags, 4'hF);
      chk(event_flags[i], 0);
    end
    run(CTK_OP_ATTENTION, 4'h0, 32'h1234A5C3, 0, 1'b0, 1'b0);
    repeat (3) @(posedge pclk);
    chk(ctk_pipe_model_i.attn_seen, 32'h0000A5C3);
    chk(ctk_pipe_model_i.attn_cycles, 1);
    for (int i = 0; i < 4; i++) begin
      run(CTK_OP_SEL_SETUP, 4'(4 + i), 32'hFFFFFE00 | (32'h0A5 + i), 0, 1'b0, 1'b0);
      chk({23'h0, sel_cfg[i]}, 32'h0A5 + i);
    end
    // Low bank selected: toggling the masked pins must fire the pattern event.
    run(CTK_OP_PIN_SETUP, EV_PIN, 32'h000000FF, 32'h0000005A, 1'b0, 1'b0);
    pin_low <= 32'h0000005A;
    repeat (8) @(posedge pclk);
    pin_low <= 32'h00000000;
    repeat (8) @(posedge pclk);
    chk(event_flags[EV_PIN], 1);
    flag_c_in <= 1'b1;
    run(CTK_OP_PIN_SETUP, EV_PIN, 32'h000000FF, 32'h0000005A, 1'b0, 1'b0);
    repeat (8) @(posedge pclk);
    run(CTK_OP_POLL, EV_PIN, 0, 0, 1'b0, 1'b0);
    pin_low <= 32'h0000005A;
    repeat (8) @(posedge pclk);
    pin_low <= 32'h00000000;
    repeat (8) @(posedge pclk);
    chk(event_flags[EV_PIN], 0);
    // High bank selected: the same match on the high pins fires.
    pin_high <= 32'h0000005A;
    repeat (8) @(posedge pclk);
    chk(event_flags[EV_PIN], 1);
    // Low bank, unequal sense: a match keeps the event quiet, leaving the match fires it.
    flag_c_in <= 1'b0;
    flag_z_in <= 1'b1;
    run(CTK_OP_PIN_SETUP, EV_PIN, 32'h000000FF, 32'h0000005A, 1'b0, 1'b0);
    run(CTK_OP_POLL, EV_PIN, 0, 0, 1'b0, 1'b0);
    pin_low <= 32'h0000005A;
    repeat (8) @(posedge pclk);
    chk(event_flags[EV_PIN], 0);
    pin_low <= 32'h00000000;
    repeat (8) @(posedge pclk);
    chk(event_flags[EV_PIN], 1);
    // Wait on a flag that arrives later, then on one already set.
    fork
      run(CTK_OP_WAIT, EV_SEL1 + 4'h1, 0, 0, 1'b1, 1'b1);
      begin repeat (6) @(posedge pclk); pulse(5); end
    join
    chk(ctk_pipe_model_i.res_flags[3:2], 0);
    chk({31'h0, ctk_pipe_model_i.lat >= 6}, 1);
    chk(event_flags[5], 0);
    pulse(5);
    run(CTK_OP_WAIT, EV_SEL1 + 4'h1, 0, 0, 1'b0, 1'b0); chk(ctk_pipe_model_i.lat, 2);
    d = free_running_counter + 32'd40;
    run(CTK_OP_QUEUE, 4'h0, d, 0, 1'b0, 1'b0);
    run(CTK_OP_WAIT, EV_SOLVER, 0, 0, 1'b1, 1'b1); chk(ctk_pipe_model_i.res_flags[3:2], 3);
    t = free_running_counter - d;
    chk({31'h0, t <= 3}, 1);
    // Interrupt: raise, mask, unmask, clear by writing one.
    apb(1'b1, OFS_IRQ_STATUS, 32'h0000FFFF, rd);
    apb(1'b1, OFS_IRQ_MASK, 32'h00000200, rd);
    pulse(9);
    chk(irq, 1);
    apb(1'b1, OFS_IRQ_MASK, 32'h0, rd); chk(irq, 0);
    apb(1'b1, OFS_IRQ_MASK, 32'h00000200, rd); chk(irq, 1);
    apb(1'b1, OFS_IRQ_STATUS, 32'h00000200, rd); chk(irq, 0);
    apb(1'b0, OFS_IRQ_STATUS, 32'h0, rd); chk(rd, 32'h0);
    apb(1'b1, OFS_FLAGS, 32'h0, rd);
    apb(1'b0, OFS_FLAGS, 32'h0, rd); chk(rd[9], 1);
    finish_test();
  end
endmodule // test_ctk_event_tracker
